// >>> rtl/modbus_rtu_slave.sv
// modbus rtu slave: request parsing, parameter access and reply framing
// assumes a uart that hands over one byte plus parity per pulse and
// takes one byte per valid/ready handshake; parameters live outside
`timescale 1ns/100ps
`default_nettype none

module modbus_rtu_slave #(
    parameter logic [23:0] gap_cycles = 24'(modbus_pkg::GAP_CYCLES)
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] slave_address,
    input wire modbus_pkg::parity_mode_type parity_mode,
    input wire logic reply_count_format_select,
    input wire logic rx_valid,
    input wire modbus_pkg::serial_byte_type rx_byte,
    output logic tx_valid,
    output modbus_pkg::serial_byte_type tx_byte,
    input wire logic tx_ready,
    output logic mem_req,
    output modbus_pkg::mem_cmd_type mem_cmd,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    output logic parity_error,
    output logic crc_error
);
    typedef enum logic [1:0] {st_collect, st_fetch, st_write, st_send} state_type;

    state_type state;
    logic [7:0] frame [0:7];
    logic [15:0] word_buf [0:15];
    logic [4:0] idx;
    logic [15:0] crc;
    logic par_bad;
    logic [23:0] idle;
    logic gap_met;
    logic end_now;
    logic rx_bad;
    logic [15:0] word_count;
    logic [15:0] start_addr;
    logic addr_hit;
    logic fn_ok;
    logic crc_good;
    logic frame_good;
    logic bcast;
    logic echo;
    logic fmt;
    logic [4:0] word_n;
    logic [3:0] word_k;
    logic [5:0] tx_idx;
    logic [5:0] tx_len;
    logic [15:0] tx_crc;
    logic [7:0] next_tx_data;
    logic tx_take;
    logic tx_done;
    logic [5:0] head_len;
    logic [5:0] data_pos;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // silence counter since the last received byte
    always_ff @(posedge sys_clk) begin
        if (rst) idle <= 24'h000000;
        else if (rx_valid) idle <= 24'h000000;
        else if (idle < gap_cycles) idle <= idle + 24'h000001;
    end

    assign gap_met = idle >= gap_cycles;
    // frame closes on the last quiet cycle before the silence is complete
    assign end_now = state == st_collect && idx != 5'h00 && !rx_valid
        && idle == gap_cycles - 24'h000001;
    assign rx_bad = parity_mode != modbus_pkg::PAR_NONE
        && rx_byte.parity != modbus_pkg::parity_bit(parity_mode, rx_byte.data);

    // frame capture with running crc; bytes during a reply are ignored
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            idx <= 5'h00;
            crc <= modbus_pkg::CRC_INIT;
            par_bad <= 1'h0;
        end else if (state == st_collect && rx_valid) begin
            if (idx < modbus_pkg::REQ_BYTES) frame[idx[2:0]] <= rx_byte.data;
            if (idx != 5'h1F) idx <= idx + 5'h01;
            if (idx == 5'h00) begin
                crc <= modbus_pkg::crc_step(modbus_pkg::CRC_INIT, rx_byte.data);
                par_bad <= rx_bad;
            end else begin
                crc <= modbus_pkg::crc_step(crc, rx_byte.data);
                par_bad <= par_bad | rx_bad;
            end
        end else if (end_now) begin
            idx <= 5'h00;
        end
    end

    // request decode
    assign word_count = {frame[4], frame[5]};
    assign start_addr = {frame[2], frame[3]};
    assign addr_hit = frame[0] == modbus_pkg::BROADCAST_ADDR
        || (frame[0] == slave_address && slave_address != modbus_pkg::BROADCAST_ADDR
        && slave_address <= modbus_pkg::MAX_SLAVE_ADDR);
    assign fn_ok = (frame[1] == modbus_pkg::FN_READ && word_count != 16'h0000
        && word_count <= modbus_pkg::MAX_WORDS) || frame[1] == modbus_pkg::FN_WRITE;
    assign crc_good = crc == modbus_pkg::CRC_RESIDUE;
    assign frame_good = idx == modbus_pkg::REQ_BYTES && crc_good && !par_bad && addr_hit && fn_ok;

    // error pulses
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            parity_error <= 1'h0;
            crc_error <= 1'h0;
        end else begin
            parity_error <= state == st_collect && rx_valid && rx_bad;
            crc_error <= end_now && !crc_good;
        end
    end

    assign tx_take = tx_valid && tx_ready;
    assign tx_done = tx_take && tx_idx == tx_len - 6'h01;
    assign head_len = fmt ? 6'h02 : 6'h01;

    // control and parameter access
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= st_collect;
            mem_req <= 1'h0;
            mem_cmd <= '0;
            bcast <= 1'h0;
            echo <= 1'h0;
            fmt <= 1'h0;
            word_n <= 5'h00;
            word_k <= 4'h0;
            tx_len <= 6'h00;
        end else begin
            case (state)
                st_collect: begin
                    if (end_now && frame_good) begin
                        bcast <= frame[0] == modbus_pkg::BROADCAST_ADDR;
                        fmt <= reply_count_format_select;
                        word_n <= word_count[4:0];
                        word_k <= 4'h0;
                        if (frame[1] == modbus_pkg::FN_WRITE) begin
                            state <= st_write;
                            echo <= 1'h1;
                            mem_req <= 1'h1;
                            mem_cmd <= '{we: 1'h1, addr: start_addr, wdata: word_count};
                        end else if (frame[0] != modbus_pkg::BROADCAST_ADDR) begin
                            state <= st_fetch;
                            echo <= 1'h0;
                            mem_req <= 1'h1;
                            mem_cmd <= '{we: 1'h0, addr: start_addr, wdata: 16'h0000};
                        end
                    end
                end
                st_fetch: begin
                    if (mem_ack) begin
                        word_buf[word_k] <= mem_rdata;
                        word_k <= word_k + 4'h1;
                        mem_cmd.addr <= mem_cmd.addr + 16'h0001;
                        if ({1'h0, word_k} == word_n - 5'h01) begin
                            mem_req <= 1'h0;
                            state <= st_send;
                            tx_len <= modbus_pkg::READ_FIXED_LEN + head_len + {word_n, 1'h0};
                        end
                    end
                end
                st_write: begin
                    if (mem_ack) begin
                        mem_req <= 1'h0;
                        tx_len <= modbus_pkg::ECHO_LEN;
                        state <= bcast ? st_collect : st_send;
                    end
                end
                st_send: begin
                    if (tx_done) state <= st_collect;
                end
                default: state <= st_collect;
            endcase
        end
    end

    // reply byte at the current position
    assign data_pos = tx_idx - 6'h02 - head_len;
    always_comb begin
        next_tx_data = 8'h00;
        if (echo) next_tx_data = frame[tx_idx[2:0]];
        else if (tx_idx == 6'(modbus_pkg::IDX_ADDR)) next_tx_data = frame[0];
        else if (tx_idx == 6'(modbus_pkg::IDX_FUNC)) next_tx_data = modbus_pkg::FN_READ;
        else if (tx_idx == tx_len - 6'h02) next_tx_data = tx_crc[7:0];
        else if (tx_idx == tx_len - 6'h01) next_tx_data = tx_crc[15:8];
        else if (fmt && tx_idx == 6'h02) next_tx_data = 8'h00;
        else if (tx_idx == head_len + 6'h01) next_tx_data = {2'h0, word_n, 1'h0};
        else if (data_pos[0]) next_tx_data = word_buf[data_pos[4:1]][7:0];
        else next_tx_data = word_buf[data_pos[4:1]][15:8];
    end

    // byte handshake toward the uart with running crc
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_valid <= 1'h0;
            tx_byte <= '0;
            tx_idx <= 6'h00;
            tx_crc <= modbus_pkg::CRC_INIT;
        end else if (state != st_send) begin
            tx_valid <= 1'h0;
            tx_idx <= 6'h00;
            tx_crc <= modbus_pkg::CRC_INIT;
        end else if (tx_take) begin
            tx_valid <= 1'h0;
            tx_idx <= tx_idx + 6'h01;
            if (tx_idx < tx_len - 6'h02) tx_crc <= modbus_pkg::crc_step(tx_crc, tx_byte.data);
        end else if (!tx_valid && (tx_idx != 6'h00 || gap_met)) begin
            tx_valid <= 1'h1;
            tx_byte.data <= next_tx_data;
            tx_byte.parity <= modbus_pkg::parity_bit(parity_mode, next_tx_data);
        end
    end

    sequence s_read_accept;
        end_now && frame_good && frame[1] == modbus_pkg::FN_READ && frame[0] != modbus_pkg::BROADCAST_ADDR;
    endsequence
    sequence s_fetch_begin;
        state == st_fetch && mem_req && !mem_cmd.we && mem_cmd.addr == $past(start_addr);
    endsequence

    a_read_start: assert property (s_read_accept |=> s_fetch_begin)
        else $error("accepted read did not start fetching");
    a_reject_frame: assert property (end_now && !frame_good |=> state == st_collect && !mem_req)
        else $error("bad or foreign frame was acted on");
    a_bcast_silent: assert property (tx_valid |-> state == st_send && !bcast)
        else $error("reply sent outside send or to broadcast");
    a_parity_flag: assert property (state == st_collect && rx_valid && rx_bad |=> parity_error)
        else $error("parity mismatch not reported");
    a_even_parity: assert property (tx_valid && parity_mode == modbus_pkg::PAR_EVEN
        |-> tx_byte.parity == ^tx_byte.data)
        else $error("even parity bit wrong");
    a_odd_parity: assert property (tx_valid && parity_mode == modbus_pkg::PAR_ODD
        |-> tx_byte.parity == ~^tx_byte.data)
        else $error("odd parity bit wrong");
    a_crc_restart: assert property (state == st_collect && rx_valid && idx == 5'h00
        |=> crc == modbus_pkg::crc_step(modbus_pkg::CRC_INIT, $past(rx_byte.data)))
        else $error("crc not restarted at frame start");
    a_crc_report: assert property (end_now && !crc_good |=> crc_error ##1 !crc_error)
        else $error("crc failure not pulsed once");
    a_gap_discard: assert property (end_now |=> idx == 5'h00 && state != st_send)
        else $error("frame not closed at silence");
    a_echo_bytes: assert property (tx_valid && echo |-> tx_byte.data == frame[tx_idx[2:0]])
        else $error("write echo differs from request");
    // zero high count byte taken, one idle cycle, then the low count byte
    sequence s_count_pair;
        tx_byte.data == 8'h00 ##1 !tx_valid ##1 tx_valid && tx_idx == 6'h03 && tx_byte.data == {2'h0, word_n, 1'h0};
    endsequence
    a_count_high: assert property (tx_take && !echo && fmt && tx_idx == 6'h02 |-> s_count_pair)
        else $error("two-byte count wrong");
    a_count_single: assert property (tx_valid && !echo && !fmt && tx_idx == 6'h02
        |-> tx_byte.data == {2'h0, word_n, 1'h0})
        else $error("single count byte wrong");
    a_tx_crc_high: assert property (tx_valid && !echo && tx_idx == tx_len - 6'h01
        |-> tx_byte.data == tx_crc[15:8])
        else $error("reply crc high byte wrong");
    // frames the block must drop without acting
    a_foreign_drop: assert property (end_now && frame[0] != modbus_pkg::BROADCAST_ADDR
        && frame[0] != slave_address |=> state == st_collect && !mem_req)
        else $error("foreign frame was acted on");
    a_range_drop: assert property (end_now && slave_address > modbus_pkg::MAX_SLAVE_ADDR
        && frame[0] != modbus_pkg::BROADCAST_ADDR |=> state == st_collect && !mem_req)
        else $error("address above range was answered");
    a_bcast_read: assert property (end_now && frame[0] == modbus_pkg::BROADCAST_ADDR
        && frame[1] == modbus_pkg::FN_READ |=> state == st_collect && !mem_req)
        else $error("broadcast read was acted on");
    a_parity_drop: assert property (end_now && par_bad |=> state == st_collect && !mem_req)
        else $error("frame with parity error was acted on");
    a_length_drop: assert property (end_now && idx != modbus_pkg::REQ_BYTES
        |=> state == st_collect && !mem_req)
        else $error("frame of wrong length was acted on");
    // accepted write and read bounds
    a_write_start: assert property (end_now && frame_good && frame[1] == modbus_pkg::FN_WRITE
        |=> state == st_write && mem_req && mem_cmd.we && mem_cmd.wdata == $past(word_count))
        else $error("accepted write did not start");
    a_fetch_count: assert property (state == st_fetch |-> word_n != 5'h00
        && {11'h000, word_n} <= modbus_pkg::MAX_WORDS)
        else $error("read word count out of range");
    // reply check field and the silence before it
    a_tx_crc_low: assert property (tx_valid && !echo && tx_idx == tx_len - 6'h02
        |-> tx_byte.data == tx_crc[7:0])
        else $error("reply crc low byte wrong");
    a_reply_silence: assert property ($rose(tx_valid) && tx_idx == 6'h00 |-> $past(gap_met))
        else $error("reply started before bus silence");
endmodule // modbus_rtu_slave

`default_nettype wire

// >>> rtl/modbus_pkg.sv
// constants, carrier types and helper functions for the modbus rtu slave
// assumes a 100 MHz system clock and a byte-level uart outside the block
package modbus_pkg;
    // clock and inter-frame silence
    localparam int CLK_PERIOD_NS = 10;
    localparam int CHAR_TIME_NS = 1145834; // one 11-bit character at 9600 baud
    localparam int GAP_CHAR_TENTHS = 35; // silence of 3.5 characters
    localparam longint GAP_NS = (longint'(CHAR_TIME_NS) * GAP_CHAR_TENTHS + 9) / 10;
    localparam int GAP_CYCLES = int'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int GAP_WIDTH = 24;

    // crc
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000; // crc over a frame incl. its check field

    // frame layout and limits
    localparam logic [7:0] FN_READ = 8'h03;
    localparam logic [7:0] FN_WRITE = 8'h06;
    localparam logic [7:0] BROADCAST_ADDR = 8'h00;
    localparam logic [7:0] MAX_SLAVE_ADDR = 8'hF7;
    localparam logic [15:0] MAX_WORDS = 16'h0010;
    localparam logic [4:0] REQ_BYTES = 5'h08;
    localparam logic [5:0] ECHO_LEN = 6'h08;
    localparam logic [5:0] READ_FIXED_LEN = 6'h04; // address, function, two check bytes
    localparam logic [4:0] IDX_ADDR = 5'h00;
    localparam logic [4:0] IDX_FUNC = 5'h01;

    typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_mode_type;

    typedef struct packed {
        logic parity;
        logic [7:0] data;
    } serial_byte_type;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_cmd_type;

    // parity bit a transmitter puts beside a byte
    function automatic logic parity_bit(input parity_mode_type mode, input logic [7:0] data);
        case (mode)
            PAR_EVEN: parity_bit = ^data;
            PAR_ODD: parity_bit = ~^data;
            default: parity_bit = 1'h0;
        endcase
    endfunction

    // one byte through the reflected crc-16
    function automatic logic [15:0] crc_step(input logic [15:0] crc_in, input logic [7:0] data);
        logic [15:0] c;
        c = crc_in ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            if (c[0]) c = (c >> 1) ^ CRC_POLY;
            else c = c >> 1;
        end
        return c;
    endfunction
endpackage

// >>> tb/modbus_master_model.sv
// modbus master model: takes the slave's reply bytes off its uart side
// assumes the slave offers each byte by valid/ready on sys_clk
`timescale 1ns/100ps
`default_nettype none

module modbus_master_model (
    input wire logic sys_clk,
    input wire modbus_pkg::parity_mode_type parity_mode,
    input wire logic slow,
    input wire logic tx_valid,
    input wire modbus_pkg::serial_byte_type tx_byte,
    output logic tx_ready
);
    logic [7:0] got_q[$];
    int bad_par = 0;
    int stall = 0;
    // collect bytes, judge the parity bit, pace ready
    always @(posedge sys_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got_q.push_back(tx_byte.data);
            if (parity_mode == modbus_pkg::PAR_EVEN && tx_byte.parity !== ^tx_byte.data) bad_par++;
            if (parity_mode == modbus_pkg::PAR_ODD && tx_byte.parity !== ~^tx_byte.data) bad_par++;
        end
        #1;
        stall = (tx_valid === 1'b1 && !tx_ready) ? stall + 1 : 0;
        tx_ready = !slow || stall >= 3; // slow: keep each byte waiting three cycles
    end
endmodule // modbus_master_model
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the modbus rtu slave
// assumes a short gap parameter; bench acts as uart receiver and parameter store
`timescale 1ns/100ps
`default_nettype none

module tb;
    localparam int GAP = 20;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic slow = 1'b0;
    logic rx_valid = 1'b0;
    logic reply_count_format_select = 1'b0;
    logic mem_ack = 1'b0;
    logic [15:0] mem_rdata = 16'h0000;
    logic [7:0] slave_address = 8'h01;
    modbus_pkg::parity_mode_type parity_mode = modbus_pkg::PAR_EVEN;
    modbus_pkg::serial_byte_type rx_byte = '0;
    modbus_pkg::serial_byte_type tx_byte;
    modbus_pkg::mem_cmd_type mem_cmd;
    logic tx_valid, tx_ready, mem_req, parity_error, crc_error;
    logic [15:0] wr_addr, wr_data;
    int n_mismatch = 0, compares = 0, cycles = 0;
    int n_perr = 0, n_cerr = 0, n_wr = 0, n_rd = 0;

    modbus_rtu_slave #(.gap_cycles(24'(GAP))) dut (.sys_clk(sys_clk), .rst(rst), .slave_address(slave_address),
        .parity_mode(parity_mode), .reply_count_format_select(reply_count_format_select), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .mem_req(mem_req),
        .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .parity_error(parity_error),
        .crc_error(crc_error));
    modbus_master_model far_end (.sys_clk(sys_clk), .parity_mode(parity_mode), .slow(slow),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));

    always #5 sys_clk = ~sys_clk;

    function automatic logic [15:0] word_of(input logic [15:0] a);
        return a ^ 16'h5A3C;
    endfunction

    // parameter store: ack every other cycle while a request is pending
    always @(posedge sys_clk) begin
        n_perr += (parity_error === 1'b1);
        n_cerr += (crc_error === 1'b1);
        #1;
        mem_ack = mem_req === 1'b1 && !mem_ack;
        mem_rdata = word_of(mem_cmd.addr);
        if (mem_ack && mem_cmd.we) begin n_wr++; wr_addr = mem_cmd.addr; wr_data = mem_cmd.wdata; end
        else if (mem_ack) n_rd++;
    end

    task automatic give_verdict();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // cut a hang short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin n_mismatch++; give_verdict(); end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin n_mismatch++; $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end
    endtask

    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction

    // send one frame with its check field; bad picks a byte with wrong parity
    task automatic send(input logic [7:0] b[$], input int bad, input logic [15:0] crc_x);
        logic [15:0] c;
        logic p;
        c = crc16(b) ^ crc_x;
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        foreach (b[i]) begin
            @(posedge sys_clk); #1;
            p = (parity_mode == modbus_pkg::PAR_EVEN) ? ^b[i] : (parity_mode == modbus_pkg::PAR_ODD) ? ~^b[i] : 1'b0;
            rx_valid = 1'b1;
            rx_byte = modbus_pkg::serial_byte_type'({p ^ (i == bad), b[i]});
            @(posedge sys_clk); #1;
            rx_valid = 1'b0;
        end
    endtask

    // wait for the reply, then a long silence, and compare every byte
    task automatic expect_reply(input logic [7:0] e[$]);
        logic [15:0] c;
        c = crc16(e);
        if (e.size() > 0) begin e.push_back(c[7:0]); e.push_back(c[15:8]); end
        repeat (400) if (far_end.got_q.size() < e.size()) @(posedge sys_clk);
        repeat (4 * GAP) @(posedge sys_clk);
        #1;
        check(far_end.got_q.size(), e.size());
        foreach (e[i]) if (i < far_end.got_q.size()) check(far_end.got_q[i], e[i]);
        far_end.got_q.delete();
    endtask

    task automatic do_read(input logic [15:0] a, input logic [15:0] n, input logic fmt, input logic [7:0] who);
        logic [7:0] e[$];
        logic [15:0] w;
        int r0;
        logic ok;
        r0 = n_rd;
        ok = who == 8'h01 && n >= 1 && n <= 16;
        reply_count_format_select = fmt;
        send('{who, 8'h03, a[15:8], a[7:0], n[15:8], n[7:0]}, -1, 16'h0000);
        if (ok) begin
            e = '{who, 8'h03};
            if (fmt) e.push_back(8'h00);
            e.push_back(8'(2 * n));
            for (int i = 0; i < n; i++) begin w = word_of(16'(a + i)); e.push_back(w[15:8]); e.push_back(w[7:0]); end
        end
        expect_reply(e);
        check(n_rd - r0, ok ? n : 0);
    endtask

    task automatic do_write(input logic [7:0] who, input int bad, input logic [15:0] crc_x);
        logic [7:0] q[$];
        int w0, p0, c0;
        logic good;
        q = '{who, 8'h06, 8'h10, 8'h00, 8'h27, 8'h10};
        w0 = n_wr; p0 = n_perr; c0 = n_cerr;
        good = bad < 0 && crc_x == 16'h0000;
        send(q, bad, crc_x);
        if (who == 8'h01 && good) expect_reply(q);
        else expect_reply('{});
        check(n_wr - w0, (who <= 8'h01) && good);
        if (n_wr != w0) check({wr_addr, wr_data}, 32'h10002710);
        check(n_perr - p0, bad >= 0);
        check(n_cerr - c0, crc_x != 16'h0000);
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        check(crc16('{8'h01, 8'h06, 8'h10, 8'h00, 8'h27, 8'h10}), 32'h3697);
        // each parity mode with a prompt receiver, except even parity, which uses the slow one
        for (int m = 0; m < 3; m++) begin
            parity_mode = modbus_pkg::parity_mode_type'(m);
            slow = m[0];
            do_write(8'h01, -1, 16'h0000);
            do_read(16'h1001, 16'h0005, 1'b0, 8'h01);
        end
        do_read(16'h1000, 16'h0010, 1'b1, 8'h01);
        do_read(16'h1000, 16'h0011, 1'b0, 8'h01);
        do_read(16'h1000, 16'h0000, 1'b0, 8'h01);
        do_read(16'h1002, 16'h0002, 1'b0, 8'h00);
        do_write(8'h02, -1, 16'h0000);
        // own address above the legal range: unicast never matches
        slave_address = 8'hF8;
        do_write(8'hF8, -1, 16'h0000);
        slave_address = 8'h01;
        do_write(8'h00, -1, 16'h0000);
        do_write(8'h01, 3, 16'h0000);
        do_write(8'h01, -1, 16'h0001);
        // partial frame broken by a gap, then a clean write
        send('{8'h01, 8'h06, 8'h10}, -1, 16'h0000);
        expect_reply('{});
        do_write(8'h01, -1, 16'h0000);
        check(far_end.bad_par, 0);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
